// >>> core/hbc_chopper.sv
// module: h-bridge pwm current chopper control logic
`timescale 1ns/100ps
// What this block does
// - enable low: both outputs high impedance
// - direction selects which output is high
// - trip stops drive for rest of period
// - each period starts driving until trip
// - trip when five times sense reaches scaled reference
// - five-bit code scales chopping current
// - codes 0-7 give 0 to 34 percent
// - codes 8-15 give 38 to 67 percent
// - codes 16-23 give 71 to 90 percent
// - codes 24-31 give 92 to 100 percent
// - fast decay reverses, then off near zero
// - slow decay turns both low sides on
// - decay pin low slow, open mixed, high fast
// - mixed: fast, then slow after 75 percent
// - sense ignored during blanking after drive start
// - logic reset clears state, bridge off
// - sleep disables bridge and freezes counters
// - persisting overcurrent latches off with fault
module hbc_chopper
    import hbc_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // host control pins
    input wire logic logic_reset_n,
    input wire logic low_power_n,
    input wire logic bridge_enable_in,
    input wire logic direction_in,
    input wire logic [LEVEL_W-1:0] current_level,
    input wire logic decay_high,
    input wire logic decay_low,
    // analog stand-ins
    input wire logic [11:0] sense_mv,
    input wire logic [11:0] vref_mv,
    input wire logic zero_cross,
    input wire logic overcurrent_in,
    // bridge gate drive: high side and low side per leg
    output logic hs_a,
    output logic ls_a,
    output logic hs_b,
    output logic ls_b,
    output logic bridge_out_a_oe_n,
    output logic bridge_out_b_oe_n,
    // status
    output logic fault_flag_n,
    output logic overcurrent_shutdown,
    output logic [PCT_W-1:0] level_pct
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    hbc_state_t state;
    hbc_state_t next_state;
    logic [CNT_W-1:0] period_cnt;
    logic [CNT_W-1:0] phase_cnt;
    logic [CNT_W-1:0] ocp_cnt;
    logic latched_off;
    logic tripped;
    logic dac_trip;
    logic [PCT_W-1:0] dac_pct;

    hbc_level_dac u_dac (
        .level_code(current_level),
        .sense_mv(sense_mv),
        .vref_mv(vref_mv),
        .level_pct(dac_pct),
        .trip(dac_trip)
    );

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // pin read as two comparator levels; neither means the pin floats
    wire hbc_decay_t decay_mode = decay_low ? HBC_DECAY_SLOW :
                                  decay_high ? HBC_DECAY_FAST : HBC_DECAY_MIXED;
    // dead and blanking counts both run on phase_cnt, cleared on every state change except the drop to off in sleep
    wire hold = !logic_reset_n || rst;
    wire asleep = !low_power_n;
    wire run = bridge_enable_in && !latched_off;
    wire period_end = (period_cnt == CNT_W'(PWM_PERIOD_CYC - 1));
    wire past_mixed = (period_cnt >= CNT_W'(MIXED_CYC));
    wire dead_done = (phase_cnt >= CNT_W'(DEAD_CYC - 1));
    wire blank_done = (phase_cnt >= CNT_W'(BLANK_CYC - 1));
    wire sense_trip = dac_trip && blank_done;
    wire ocp_expired = (ocp_cnt >= CNT_W'(OCP_CYC - 1));
    wire want_slow = (decay_mode == HBC_DECAY_SLOW) ||
                     (decay_mode == HBC_DECAY_MIXED && past_mixed);

    always_comb begin
        next_state = state;
        unique case (state)
            HBC_ST_OFF, HBC_ST_IDLE: begin
                if (period_end) begin
                    next_state = HBC_ST_DEAD_DRIVE;
                end
            end
            HBC_ST_DEAD_DRIVE: begin
                if (dead_done) begin
                    next_state = HBC_ST_DRIVE;
                end
            end
            HBC_ST_DRIVE: begin
                if (sense_trip || period_end) begin
                    next_state = HBC_ST_DEAD_DECAY;
                end
            end
            HBC_ST_DEAD_DECAY: begin
                // drive cut by the period boundary, not by a trip: drive again
                if (period_end || (dead_done && !tripped)) begin
                    next_state = HBC_ST_DEAD_DRIVE;
                end else if (dead_done) begin
                    next_state = want_slow ? HBC_ST_SLOW : HBC_ST_FAST;
                end
            end
            HBC_ST_FAST: begin
                if (period_end) begin
                    next_state = HBC_ST_DEAD_DRIVE;
                end else if (want_slow) begin
                    // one leg swaps high side for low side here, so pass the off gap
                    next_state = HBC_ST_DEAD_DECAY;
                end else if (zero_cross) begin
                    next_state = HBC_ST_IDLE;
                end
            end
            HBC_ST_SLOW: begin
                if (period_end) begin
                    next_state = HBC_ST_DEAD_DRIVE;
                end
            end
            default: next_state = HBC_ST_OFF;
        endcase
    end

    // fast decay reverses the drive; direction is read every cycle, not held per state
    wire drive_fwd = (state == HBC_ST_DRIVE) && direction_in;
    wire drive_rev = (state == HBC_ST_DRIVE) && !direction_in;
    wire fast_fwd = (state == HBC_ST_FAST) && !direction_in;
    wire fast_rev = (state == HBC_ST_FAST) && direction_in;
    wire slow_on = (state == HBC_ST_SLOW);
    wire next_hs_a = drive_fwd || fast_fwd;
    wire next_ls_b = drive_fwd || fast_fwd || slow_on;
    wire next_hs_b = drive_rev || fast_rev;
    wire next_ls_a = drive_rev || fast_rev || slow_on;

    // ------------------------------------------------------------
    // sequential
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (hold) begin
            state <= HBC_ST_OFF;
            period_cnt <= '0;
            phase_cnt <= '0;
            tripped <= 1'b0;
        end else if (asleep) begin
            // sleep freezes every counter; the period resumes where it stopped
            state <= HBC_ST_OFF;
        end else if (!run) begin
            // the period counter runs while disabled so the pwm grid stays fixed
            state <= HBC_ST_OFF;
            period_cnt <= period_end ? '0 : period_cnt + CNT_W'(1);
            phase_cnt <= '0;
            tripped <= 1'b0;
        end else begin
            state <= next_state;
            period_cnt <= period_end ? '0 : period_cnt + CNT_W'(1);
            phase_cnt <= (next_state != state) ? '0 : phase_cnt + CNT_W'(1);
            if (period_end) begin
                tripped <= 1'b0;
            end else if (state == HBC_ST_DRIVE && sense_trip) begin
                tripped <= 1'b1;
            end
        end
    end

    // overcurrent must persist before the latch; only a logic reset or rst clears it
    always_ff @(posedge core_clk) begin
        if (hold) begin
            ocp_cnt <= '0;
            latched_off <= 1'b0;
        end else if (!asleep) begin
            // count saturates so a long fault cannot wrap back below the limit
            ocp_cnt <= overcurrent_in ? (ocp_expired ? ocp_cnt : ocp_cnt + CNT_W'(1)) : '0;
            if (overcurrent_in && ocp_expired) begin
                latched_off <= 1'b1;
            end
        end
    end

    // gate drives are registered from the present state, one cycle behind it
    // a leg is released to high impedance whenever neither of its switches is on
    always_ff @(posedge core_clk) begin
        if (hold || asleep || !run) begin
            hs_a <= 1'b0;
            ls_a <= 1'b0;
            hs_b <= 1'b0;
            ls_b <= 1'b0;
            bridge_out_a_oe_n <= 1'b1;
            bridge_out_b_oe_n <= 1'b1;
        end else begin
            hs_a <= next_hs_a;
            ls_a <= next_ls_a;
            hs_b <= next_hs_b;
            ls_b <= next_ls_b;
            bridge_out_a_oe_n <= !(next_hs_a || next_ls_a);
            bridge_out_b_oe_n <= !(next_hs_b || next_ls_b);
        end
    end

    always_ff @(posedge core_clk) begin
        if (hold) begin
            fault_flag_n <= 1'b1;
            overcurrent_shutdown <= 1'b0;
            level_pct <= '0;
        end else begin
            // level_pct lets the host read back the decoded setting
            fault_flag_n <= !latched_off;
            overcurrent_shutdown <= latched_off;
            level_pct <= dac_pct;
        end
    end
endmodule

// >>> core/hbc_level_dac.sv
// module: current-level code to percent of full scale and trip compare
`timescale 1ns/100ps
module hbc_level_dac
    import hbc_pkg::*;
(
    // code and analog stand-ins
    input wire logic [LEVEL_W-1:0] level_code,
    input wire logic [11:0] sense_mv,
    input wire logic [11:0] vref_mv,
    // result
    output logic [PCT_W-1:0] level_pct,
    output logic trip
);
    logic [PCT_W-1:0] table_pct [0:31];
    assign table_pct = '{
        7'h00, 7'h05, 7'h0A, 7'h0F, 7'h14, 7'h18, 7'h1D, 7'h22,
        7'h26, 7'h2B, 7'h2F, 7'h33, 7'h38, 7'h3C, 7'h3F, 7'h43,
        7'h47, 7'h4A, 7'h4D, 7'h50, 7'h53, 7'h56, 7'h58, 7'h5A,
        7'h5C, 7'h5E, 7'h60, 7'h61, 7'h62, 7'h63, 7'h64, 7'h64
    };
    wire [23:0] lhs = 24'(sense_mv) * 24'(SENSE_GAIN) * 24'(PCT_FULL);
    wire [23:0] rhs = 24'(vref_mv) * 24'(level_pct);
    assign level_pct = table_pct[level_code];
    assign trip = (lhs >= rhs);
endmodule

// >>> core/hbc_pkg.sv
// package: constants and types for the h-bridge current chopper
package hbc_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int PWM_KHZ = 50;
    localparam int PWM_PERIOD_CYC = (CLK_MHZ * 1000) / PWM_KHZ;
    localparam int BLANK_NS = 3750;
    localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
    localparam int DEAD_NS = 400;
    localparam int DEAD_CYC = (DEAD_NS * CLK_MHZ + 999) / 1000;
    localparam int MIXED_PCT = 75;
    localparam int MIXED_CYC = (PWM_PERIOD_CYC * MIXED_PCT) / 100;
    localparam int OCP_NS = 3000;
    localparam int OCP_CYC = (OCP_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 12;
    localparam int SENSE_GAIN = 5;
    localparam int LEVEL_W = 5;
    localparam int PCT_W = 7;
    localparam logic [PCT_W-1:0] PCT_FULL = 7'h64;

    // ------------------------------------------------------------
    // decay select and chopper state codes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        HBC_DECAY_SLOW = 2'b00,
        HBC_DECAY_MIXED = 2'b01,
        HBC_DECAY_FAST = 2'b10
    } hbc_decay_t;

    typedef enum logic [2:0] {
        HBC_ST_OFF = 3'b000,
        HBC_ST_DEAD_DRIVE = 3'b001,
        HBC_ST_DRIVE = 3'b010,
        HBC_ST_DEAD_DECAY = 3'b011,
        HBC_ST_FAST = 3'b100,
        HBC_ST_SLOW = 3'b101,
        HBC_ST_IDLE = 3'b110
    } hbc_state_t;
endpackage

// >>> test/hbc_chopper_checker.sv
// checker: port assertions for the h-bridge chopper
`timescale 1ns/100ps
module hbc_chk (
    // ----------
    // watched ports
    // ----------
    input wire logic core_clk,
    input wire logic rst,
    input wire logic logic_reset_n,
    input wire logic low_power_n,
    input wire logic bridge_enable_in,
    input wire logic overcurrent_in,
    input wire logic hs_a,
    input wire logic ls_a,
    input wire logic hs_b,
    input wire logic ls_b,
    input wire logic bridge_out_a_oe_n,
    input wire logic bridge_out_b_oe_n,
    input wire logic fault_flag_n,
    input wire logic overcurrent_shutdown
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [9:0] oc_cnt;
    wire logic gates_off = !(hs_a || ls_a || hs_b || ls_b);
    // saturating run length of the analog limit; sleep and reset clear it
    always_ff @(posedge core_clk) begin
        if (rst || !logic_reset_n || !low_power_n || !overcurrent_in)
            oc_cnt <= 10'h000;
        else if (oc_cnt != 10'h3FF)
            oc_cnt <= oc_cnt + 10'h001;
    end
    a_enable_hiz: assert property (!bridge_enable_in [*2] |-> bridge_out_a_oe_n && bridge_out_b_oe_n)
        else $error("bridge driven while disabled");
    a_leg_exclusive: assert property (!(hs_a && ls_a) && !(hs_b && ls_b))
        else $error("both switches of one leg on");
    a_gap_leg_a: assert property ($fell(hs_a) |-> !ls_a)
        else $error("no off gap on leg a");
    a_gap_leg_b: assert property ($fell(hs_b) |-> !ls_b)
        else $error("no off gap on leg b");
    a_reset_off: assert property (!logic_reset_n |=> gates_off && fault_flag_n)
        else $error("bridge on after logic reset");
    a_sleep_off: assert property (!low_power_n |=> gates_off)
        else $error("bridge on in sleep");
    a_fault_pair: assert property (fault_flag_n != overcurrent_shutdown)
        else $error("fault pins disagree");
    a_fault_hold: assert property (overcurrent_shutdown && logic_reset_n |=> overcurrent_shutdown)
        else $error("shutdown released without reset");
    a_oc_latch: assert property (oc_cnt >= 10'h25D |-> overcurrent_shutdown && gates_off)
        else $error("persisting overcurrent not latched");
    c_fault: cover property (!fault_flag_n);
    c_slow: cover property (ls_a && ls_b);
    c_fast: cover property ($fell(hs_a) ##[1:100] hs_b && ls_a);
endmodule
bind hbc_chopper hbc_chk u_chk (.core_clk, .rst, .logic_reset_n, .low_power_n, .bridge_enable_in,
    .overcurrent_in, .hs_a, .ls_a, .hs_b, .ls_b, .bridge_out_a_oe_n, .bridge_out_b_oe_n,
    .fault_flag_n, .overcurrent_shutdown);

// >>> test/hbc_winding_model.sv
// model: winding current and sense feedback
`timescale 1ns/100ps
module hbc_wind (
    // gate drives and decay rate
    input wire logic core_clk,
    input wire logic hs_a,
    input wire logic ls_a,
    input wire logic hs_b,
    input wire logic ls_b,
    input wire logic [1:0] fall_div,
    // sense feedback
    output logic [11:0] sense_mv,
    output logic zero_cross
);
    int i = 0;
    int t = 0;
    wire logic [3:0] g = {hs_a, ls_a, hs_b, ls_b};
    // decay is slowed by fall_div so that mixed decay can outlast 75 percent
    always @(posedge core_clk) begin
        t <= t + 1;
        if (g == 4'h9 && i >= 0)
            i <= i + 1;
        else if (g == 4'h6 && i <= 0)
            i <= i - 1;
        else if (i != 0 && t % (1 << fall_div) == 0)
            i <= (i > 0) ? i - 1 : i + 1;
    end
    assign sense_mv = 12'(i < 0 ? -i : i);
    assign zero_cross = (i == 0);
endmodule

// >>> test/tb.sv
// testbench: scenario sequences for the h-bridge chopper
`timescale 1ns/100ps
module tb import hbc_pkg::*;;
    // ----------
    // stimulus and observation
    // ----------
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic logic_reset_n = 1'b1;
    logic low_power_n = 1'b1;
    logic bridge_enable_in = 1'b0;
    logic direction_in = 1'b1;
    logic [LEVEL_W-1:0] current_level = 5'h00;
    logic decay_high = 1'b0;
    logic decay_low = 1'b0;
    logic [11:0] vref_mv = 12'hFA0;
    logic overcurrent_in = 1'b0;
    logic [1:0] fall_div = 2'h0;
    logic [11:0] sense_mv;
    logic zero_cross, hs_a, ls_a, hs_b, ls_b, bridge_out_a_oe_n, bridge_out_b_oe_n;
    logic fault_flag_n, overcurrent_shutdown;
    logic [PCT_W-1:0] level_pct;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    int n;
    int t0;
    int pct_tab[32] = '{0, 5, 10, 15, 20, 24, 29, 34, 38, 43, 47, 51, 56, 60, 63, 67,
        71, 74, 77, 80, 83, 86, 88, 90, 92, 94, 96, 97, 98, 99, 100, 100};
    hbc_chopper u_dut (.core_clk, .rst, .logic_reset_n, .low_power_n, .bridge_enable_in,
        .direction_in, .current_level, .decay_high, .decay_low, .sense_mv, .vref_mv, .zero_cross,
        .overcurrent_in, .hs_a, .ls_a, .hs_b, .ls_b, .bridge_out_a_oe_n, .bridge_out_b_oe_n,
        .fault_flag_n, .overcurrent_shutdown, .level_pct);
    hbc_wind u_wind (.core_clk, .hs_a, .ls_a, .hs_b, .ls_b, .fall_div, .sense_mv, .zero_cross);
    wire logic [5:0] outs = {bridge_out_a_oe_n, bridge_out_b_oe_n, hs_a, ls_a, hs_b, ls_b};
    always #2.5 core_clk = ~core_clk;
    // the run needs about 30000 cycles; a hang stops here
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            error_cnt++;
            final_report();
        end
    end
    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    // bounded wait for gate pattern hs_a ls_a hs_b ls_b; n gives cycles spent
    task automatic wait_pat(logic [3:0] p, int lim);
        n = 0;
        while (outs[3:0] !== p && n < lim) begin
            tick(1);
            n++;
        end
        chk("gate pattern", outs[3:0], p);
    endtask
    task automatic set_in(logic d, logic dh, logic dl, logic [4:0] c, logic [1:0] f);
        @(posedge core_clk);
        direction_in <= d;
        decay_high <= dh;
        decay_low <= dl;
        current_level <= c;
        fall_div <= f;
        #1;
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        tick(1);
        chk("reset outs", {level_pct, fault_flag_n, outs}, {7'h00, 1'b1, 6'h30});
        for (int c = 0; c < 32; c++) begin
            set_in(1'b1, 1'b1, 1'b0, 5'(c), 2'h0);
            tick(3);
            chk("level pct", level_pct, 16'(pct_tab[c]));
        end
        $display("test level table done");
        @(posedge core_clk) bridge_enable_in <= 1'b1;
        wait_pat(4'h9, 9000);
        chk("oe drive", outs[5:4], 2'h0);
        wait_pat(4'h0, 1000);
        chk("on time", n >= 795 && n <= 806, 1'b1);
        wait_pat(4'h6, 200);
        chk("dead gap", n >= 75, 1'b1);
        wait_pat(4'h0, 1000);
        $display("test fast decay done");
        set_in(1'b0, 1'b0, 1'b1, 5'h00, 2'h0);
        wait_pat(4'h6, 4000);
        t0 = cyc;
        wait_pat(4'h0, 1000);
        chk("blank time", n >= 748 && n <= 753, 1'b1);
        wait_pat(4'h5, 200);
        wait_pat(4'h6, 4000);
        chk("period", 16'(cyc - t0), 16'(4000));
        wait_pat(4'h5, 2000);
        tick(1000);
        $display("test slow decay done");
        set_in(1'b1, 1'b0, 1'b0, 5'h1F, 2'h2);
        wait_pat(4'h9, 4000);
        t0 = cyc;
        wait_pat(4'h6, 1000);
        wait_pat(4'h5, 3000);
        chk("mixed switch", cyc - t0 >= 2912 && cyc - t0 <= 3008, 1'b1);
        @(posedge core_clk) bridge_enable_in <= 1'b0;
        tick(3);
        chk("disabled outs", outs, 6'h30);
        $display("test mixed decay done");
        @(posedge core_clk) bridge_enable_in <= 1'b1;
        wait_pat(4'h9, 9000);
        t0 = cyc;
        @(posedge core_clk) low_power_n <= 1'b0;
        tick(500);
        chk("sleep outs", outs, 6'h30);
        @(posedge core_clk) low_power_n <= 1'b1;
        wait_pat(4'h9, 6000);
        chk("frozen period", cyc - t0 >= 4495 && cyc - t0 <= 4505, 1'b1);
        $display("test sleep done");
        @(posedge core_clk) overcurrent_in <= 1'b1;
        tick(610);
        chk("oc latch", {fault_flag_n, overcurrent_shutdown, outs}, {2'h1, 6'h30});
        @(posedge core_clk) overcurrent_in <= 1'b0;
        tick(4100);
        chk("oc held", {fault_flag_n, overcurrent_shutdown, outs[3:0]}, 6'h10);
        @(posedge core_clk) logic_reset_n <= 1'b0;
        @(posedge core_clk) logic_reset_n <= 1'b1;
        tick(2);
        chk("oc cleared", {fault_flag_n, overcurrent_shutdown, outs[3:0]}, 6'h20);
        $display("test overcurrent done");
        final_report();
    end
endmodule
